/* common/kbg_map.vh */
// register offsets, field positions, reset values and command codes of the keyboard mailbox
`ifndef KBG_MAP_VH
`define KBG_MAP_VH
// firmware-side offsets
`define KBG_FW_KBD_DATA      12'h000
`define KBG_FW_STATUS        12'h004
`define KBG_FW_CONTROL       12'h008
`define KBG_FW_AUX_DATA      12'h00C
`define KBG_FW_KBD_FLAG      12'h010
`define KBG_FW_P92_ENABLE    12'h014
`define KBG_FW_P92_BAR       12'h018
`define KBG_FW_GATE_CTRL     12'h100
`define KBG_FW_LATCH_SET     12'h104
`define KBG_FW_LATCH_RESET   12'h108
// host I/O addresses
`define KBG_HOST_DATA        16'h0060
`define KBG_HOST_CMD         16'h0064
`define KBG_HOST_ALT         16'h0092
// status bits
`define KBG_ST_OBF           0
`define KBG_ST_IBF           1
`define KBG_ST_CD            3
`define KBG_ST_MOUSE_OUT_FULL_FLAG        5
// control bits
`define KBG_CT_GATE_SEL      0
`define KBG_CT_KBD_OVR       1
`define KBG_CT_AUX_OVR       2
`define KBG_CT_IRQ_EN        3
// alternate register bits
`define KBG_ALT_ADDR20_GATE          1
`define KBG_ALT_CPU_RESET_N          0
`define KBG_ALT_RESET        8'h00
// host commands
`define KBG_CMD_GATE         8'hD1
`define KBG_CMD_PULSE_FF     8'hFF
`define KBG_CMD_PULSE_FE     8'hFE
`define KBG_DATA_GATE_BIT    1
`endif

/* logic/kbg_gate_seq.v */
// gate command/data sequence decoder for the host address-line-20 latch
`timescale 1ns/1ps
`include "kbg_map.vh"
module kbg_gate_seq (
  // clock and reset
  input  wire       clock,
  input  wire       reset_n,
  // host write strobes
  input  wire       cmd_wr,
  input  wire       data_wr,
  input  wire [7:0] wdata,
  // decoded outcome
  output reg        take_gate,
  output reg        pass_ibf,
  output reg        gate_val
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  reg [1:0] state_r;
  reg [1:0] state_nxt;

  always @* begin
    state_nxt = state_r;
    take_gate = 1'b0;
    pass_ibf  = cmd_wr | data_wr;
    gate_val  = wdata[`KBG_DATA_GATE_BIT];
    case (state_r)
      ST_IDLE: begin
        if (cmd_wr && wdata == `KBG_CMD_GATE) begin
          state_nxt = ST_WAIT;
          pass_ibf  = 1'b0;
        end else if (cmd_wr && (wdata == `KBG_CMD_PULSE_FF || wdata == `KBG_CMD_PULSE_FE)) begin
          pass_ibf  = 1'b0;
        end
      end
      ST_WAIT: begin
        if (data_wr) begin
          take_gate = 1'b1;
          pass_ibf  = 1'b0;
          state_nxt = ST_IDLE;
        end else if (cmd_wr && wdata == `KBG_CMD_GATE) begin
          pass_ibf  = 1'b0;
        end else if (cmd_wr) begin
          pass_ibf  = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule // kbg_gate_seq

/* logic/kbg_mailbox.v */
// keyboard-controller mailbox with host and firmware ports and address-line-20 gate
`timescale 1ns/1ps
`include "kbg_map.vh"
module kbg_mailbox (
  // clock and resets
  input  wire        clock,
  input  wire        reset_n,
  input  wire        main_reset_n,
  // host I/O port
  input  wire [15:0] host_addr,
  input  wire        host_wr,
  input  wire        host_rd,
  input  wire [7:0]  host_wdata,
  output reg  [7:0]  host_rdata,
  output reg         host_rdata_oe,
  // firmware register port
  input  wire [11:0] fw_addr,
  input  wire        fw_wr,
  input  wire        fw_rd,
  input  wire [7:0]  fw_wdata,
  output reg  [7:0]  fw_rdata,
  // system and firmware events
  output reg         kbd_sys_irq,
  output reg         mouse_sys_irq,
  output reg         fw_in_full_evt,
  output reg         fw_out_empty_evt,
  // gate and cpu reset pins
  output reg         addr20_gate,
  output reg         alt_addr20_gate,
  output reg         alt_cpu_reset_n
);
  reg [7:0] out_data_r;
  reg [7:0] in_data_r;
  reg       out_buf_full_r;
  reg       in_buf_full_r;
  reg       cmd_flag_r;
  reg       kbd_pend_r;
  reg       kbd_latch_r;
  reg       mouse_out_full_flag_r;
  reg [3:0] ctrl_r;
  reg       p92_en_r;
  reg       p92_valid_r;
  reg [7:0] alt_r;
  reg       fw_gate_r;
  reg       host_gate_r;

  wire irq_gate_enable      = ctrl_r[`KBG_CT_IRQ_EN];
  wire kbd_flag_override_en = ctrl_r[`KBG_CT_KBD_OVR];
  wire aux_override_select  = ctrl_r[`KBG_CT_AUX_OVR];
  wire fw_gate_select       = ctrl_r[`KBG_CT_GATE_SEL];
  wire kbd_out_full_flag    = kbd_flag_override_en ? kbd_latch_r : kbd_pend_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire h_data_wr = host_wr && host_addr == `KBG_HOST_DATA;
  wire h_cmd_wr  = host_wr && host_addr == `KBG_HOST_CMD;
  wire h_data_rd = host_rd && host_addr == `KBG_HOST_DATA;
  wire h_stat_rd = host_rd && host_addr == `KBG_HOST_CMD;
  wire h_alt_on  = p92_en_r && p92_valid_r;
  wire h_alt_wr  = host_wr && host_addr == `KBG_HOST_ALT && h_alt_on;
  wire h_alt_rd  = host_rd && host_addr == `KBG_HOST_ALT && h_alt_on;
  wire f_kbd_wr  = fw_wr && fw_addr == `KBG_FW_KBD_DATA;
  wire f_aux_wr  = fw_wr && fw_addr == `KBG_FW_AUX_DATA;
  wire f_stat_wr = fw_wr && fw_addr == `KBG_FW_STATUS;
  wire f_flag_wr = fw_wr && fw_addr == `KBG_FW_KBD_FLAG;
  wire f_in_rd   = fw_rd && fw_addr == `KBG_FW_KBD_DATA;

  wire seq_take;
  wire seq_ibf;
  wire seq_val;
  kbg_gate_seq u_seq (
    .clock     (clock),
    .reset_n   (reset_n),
    .cmd_wr    (h_cmd_wr),
    .data_wr   (h_data_wr),
    .wdata     (host_wdata),
    .take_gate (seq_take),
    .pass_ibf  (seq_ibf),
    .gate_val  (seq_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // firmware write decode
  wire f_ctrl_wr = fw_wr && fw_addr == `KBG_FW_CONTROL;
  wire f_p92e_wr = fw_wr && fw_addr == `KBG_FW_P92_ENABLE;
  wire f_bar_wr  = fw_wr && fw_addr == `KBG_FW_P92_BAR;
  wire f_gate_wr = fw_wr && fw_addr == `KBG_FW_GATE_CTRL;
  wire f_set_wr  = fw_wr && fw_addr == `KBG_FW_LATCH_SET;
  wire f_rst_wr  = fw_wr && fw_addr == `KBG_FW_LATCH_RESET;
  wire f_out_wr  = f_kbd_wr || f_aux_wr;
  wire h_in_take = (h_data_wr || h_cmd_wr) && seq_ibf;

  ////////////////////////////////////////////////////////////////////////////
  // output buffer and keyboard flag, system-power reset domain
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_data_r     <= 8'h00;
      out_buf_full_r <= 1'b0;
      kbd_pend_r     <= 1'b0;
      kbd_latch_r    <= 1'b0;
    end else begin
      // set beats clear: a firmware write in the same cycle as a host read wins
      if (f_out_wr) begin
        out_data_r     <= fw_wdata;
        out_buf_full_r <= 1'b1;
      end else if (h_data_rd) begin
        out_buf_full_r <= 1'b0;
      end
      if (f_kbd_wr && !kbd_flag_override_en) begin
        kbd_pend_r <= 1'b1;
      end else if (h_data_rd) begin
        kbd_pend_r <= 1'b0;
      end
      // latch keeps its value across override changes, so firmware may preload it
      if (f_flag_wr) begin
        kbd_latch_r <= fw_wdata[0];
      end
    end
  end

  // mouse flag: firmware owns it while the aux override is selected
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mouse_out_full_flag_r <= 1'b0;
    end else begin
      if (aux_override_select && f_stat_wr) begin
        mouse_out_full_flag_r <= fw_wdata[`KBG_ST_MOUSE_OUT_FULL_FLAG];
      end else if (f_aux_wr && !aux_override_select) begin
        mouse_out_full_flag_r <= 1'b1;
      end else if (h_data_rd && !aux_override_select) begin
        mouse_out_full_flag_r <= 1'b0;
      end
    end
  end

  // input buffer; bytes swallowed by the gate sequence never land here
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_data_r     <= 8'h00;
      in_buf_full_r <= 1'b0;
      cmd_flag_r    <= 1'b0;
    end else begin
      if (h_in_take) begin
        in_data_r     <= host_wdata;
        in_buf_full_r <= 1'b1;
        cmd_flag_r    <= h_cmd_wr;
      end else if (f_in_rd) begin
        in_buf_full_r <= 1'b0;
      end
    end
  end

  // firmware events, one cycle each
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fw_in_full_evt   <= 1'b0;
      fw_out_empty_evt <= 1'b0;
    end else begin
      fw_in_full_evt   <= h_in_take && !in_buf_full_r;
      fw_out_empty_evt <= h_data_rd && out_buf_full_r && !f_out_wr;
    end
  end

  // firmware control registers
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r      <= 4'h0;
      p92_en_r    <= 1'b0;
      p92_valid_r <= 1'b0;
      fw_gate_r   <= 1'b0;
    end else begin
      if (f_ctrl_wr) begin
        ctrl_r <= fw_wdata[3:0];
      end
      if (f_p92e_wr) begin
        p92_en_r <= fw_wdata[0];
      end
      if (f_bar_wr) begin
        p92_valid_r <= fw_wdata[7];
      end
      if (f_gate_wr) begin
        fw_gate_r <= fw_wdata[0];
      end
    end
  end

  // host gate latch: firmware set/reset wins over a host sequence in the same cycle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      host_gate_r <= 1'b0;
    end else begin
      if (f_set_wr) begin
        host_gate_r <= 1'b1;
      end else if (f_rst_wr) begin
        host_gate_r <= 1'b0;
      end else if (seq_take) begin
        host_gate_r <= seq_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alternate register, main-power reset domain
  always @(posedge clock or negedge main_reset_n) begin
    if (!main_reset_n) begin
      alt_r <= `KBG_ALT_RESET;
    end else if (h_alt_wr) begin
      alt_r <= host_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  wire gate_now = fw_gate_select ? fw_gate_r : host_gate_r;
  // one status byte serves both the host status read and the firmware view
  reg [7:0] status_now;
  always @* begin
    status_now                = 8'h00;
    status_now[`KBG_ST_OBF]    = out_buf_full_r;
    status_now[`KBG_ST_IBF]    = in_buf_full_r;
    status_now[`KBG_ST_CD]     = cmd_flag_r;
    status_now[`KBG_ST_MOUSE_OUT_FULL_FLAG] = mouse_out_full_flag_r;
  end

  reg [7:0] fw_rd_nxt;
  reg [7:0] host_rd_nxt;
  always @* begin
    fw_rd_nxt = 8'h00;
    case (fw_addr)
      `KBG_FW_KBD_DATA:   fw_rd_nxt = in_data_r;
      `KBG_FW_STATUS:     fw_rd_nxt = status_now;
      `KBG_FW_CONTROL:    fw_rd_nxt = {4'h0, ctrl_r};
      `KBG_FW_KBD_FLAG:   fw_rd_nxt = {7'h00, kbd_out_full_flag};
      `KBG_FW_P92_ENABLE: fw_rd_nxt = {7'h00, p92_en_r};
      `KBG_FW_P92_BAR:    fw_rd_nxt = {p92_valid_r, 7'h00};
      `KBG_FW_GATE_CTRL:  fw_rd_nxt = {7'h00, gate_now};
      default:            fw_rd_nxt = 8'h00;
    endcase
    host_rd_nxt = 8'h00;
    if (h_data_rd) begin
      host_rd_nxt = out_data_r;
    end else if (h_stat_rd) begin
      host_rd_nxt = status_now;
    end else if (h_alt_rd) begin
      host_rd_nxt = alt_r;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fw_rdata      <= 8'h00;
      host_rdata    <= 8'h00;
      host_rdata_oe <= 1'b0;
    end else begin
      fw_rdata      <= fw_rd ? fw_rd_nxt : 8'h00;
      host_rdata    <= host_rd_nxt;
      host_rdata_oe <= h_data_rd || h_stat_rd || h_alt_rd;
    end
  end

  // pins: interrupts and gates lag their cause by one register
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      kbd_sys_irq     <= 1'b0;
      mouse_sys_irq   <= 1'b0;
      addr20_gate     <= 1'b0;
      alt_addr20_gate <= 1'b0;
      alt_cpu_reset_n <= 1'b1;
    end else begin
      kbd_sys_irq     <= irq_gate_enable & kbd_out_full_flag;
      mouse_sys_irq   <= irq_gate_enable & mouse_out_full_flag_r;
      addr20_gate     <= gate_now;
      alt_addr20_gate <= alt_r[`KBG_ALT_ADDR20_GATE];
      alt_cpu_reset_n <= ~alt_r[`KBG_ALT_CPU_RESET_N];
    end
  end
endmodule // kbg_mailbox

/* tb/kbg_mailbox_props.sv */
// concurrent checks on the mailbox top-level ports
`timescale 1ns/1ps
`include "kbg_map.vh"
module kbg_mailbox_props (
  // clock and resets
  input wire        clock,
  input wire        reset_n,
  input wire        main_reset_n,
  // host port
  input wire [15:0] host_addr,
  input wire        host_wr,
  input wire        host_rd,
  input wire [7:0]  host_wdata,
  input wire        host_rdata_oe,
  // firmware strobe and outputs
  input wire        fw_wr,
  input wire        kbd_sys_irq,
  input wire        mouse_sys_irq,
  input wire        fw_in_full_evt,
  input wire        fw_out_empty_evt,
  input wire        addr20_gate,
  input wire        alt_addr20_gate,
  input wire        alt_cpu_reset_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  wire data_a = host_addr == `KBG_HOST_DATA;
  wire io_wr  = host_wr && (data_a || host_addr == `KBG_HOST_CMD);
  wire silent = host_wdata == `KBG_CMD_GATE || host_wdata == `KBG_CMD_PULSE_FF || host_wdata == `KBG_CMD_PULSE_FE;
  // mirrors the gate sequence: a pulse command right after a gate command does raise input full
  reg  seq_pend_r;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      seq_pend_r <= 1'b0;
    end else if (io_wr) begin
      seq_pend_r <= !data_a && host_wdata == `KBG_CMD_GATE;
    end
  end
  a_kbd_sys_irq_cause: assert property ($changed(kbd_sys_irq) |-> $past(fw_wr, 2) || $past(host_rd, 2))
    else $error("keyboard irq moved without a cause");
  a_mouse_sys_irq_cause: assert property ($changed(mouse_sys_irq) |-> $past(fw_wr, 2) || $past(host_rd, 2))
    else $error("mouse irq moved without a cause");
  a_read_drives: assert property (host_rd && (data_a || host_addr == `KBG_HOST_CMD) |=> host_rdata_oe)
    else $error("host read left the bus undriven");
  a_empty_evt_src: assert property (fw_out_empty_evt |-> $past(host_rd && data_a))
    else $error("output empty event without a host data read");
  a_full_evt_src: assert property (fw_in_full_evt |-> $past(io_wr) || $past(io_wr, 2))
    else $error("input full event without a host write");
  a_cmd_no_full: assert property (io_wr && !data_a && silent && (!seq_pend_r || host_wdata == `KBG_CMD_GATE)
    |=> !fw_in_full_evt [*2])
    else $error("silent command raised input full");
  a_gate_cause: assert property ($changed(addr20_gate) |-> $past(host_wr, 2) || $past(fw_wr, 2))
    else $error("gate moved without a write");
  a_alt_cleared: assert property (!main_reset_n ##1 !main_reset_n |-> alt_cpu_reset_n && !alt_addr20_gate)
    else $error("alternate register not cleared by main reset");
endmodule // kbg_mailbox_props

/* tb/kbg_bus_model.sv */
// host and firmware bus master model driving one-cycle strobes
`timescale 1ns/1ps
module kbg_bus_model (
  // clock
  input  wire        clock,
  // host port
  output reg  [15:0] host_addr,
  output reg         host_wr,
  output reg         host_rd,
  output reg  [7:0]  host_wdata,
  input  wire [7:0]  host_rdata,
  // firmware port
  output reg  [11:0] fw_addr,
  output reg         fw_wr,
  output reg         fw_rd,
  output reg  [7:0]  fw_wdata,
  input  wire [7:0]  fw_rdata
);
  initial begin
    {host_addr, host_wr, host_rd, host_wdata} = 26'h0;
    {fw_addr, fw_wr, fw_rd, fw_wdata} = 22'h0;
  end
  // write data flips once taken, so a late sample never sees the old byte
  task xfer(input h, input w, input [15:0] a, input [7:0] d, output [7:0] q);
    begin
      @(posedge clock);
      if (h) begin
        host_addr <= a;
        host_wdata <= d;
        host_wr <= w;
        host_rd <= !w;
      end else begin
        fw_addr <= a[11:0];
        fw_wdata <= d;
        fw_wr <= w;
        fw_rd <= !w;
      end
      @(posedge clock);
      {host_wr, host_rd, fw_wr, fw_rd} <= 4'h0;
      host_wdata <= ~host_wdata;
      fw_wdata <= ~fw_wdata;
      #1;
      q = h ? host_rdata : fw_rdata;
    end
  endtask
endmodule // kbg_bus_model

/* tb/tb_top.sv */
// self-checking bench for the keyboard mailbox
`timescale 1ns/1ps
`include "kbg_map.vh"
module tb_top;
  reg         clock = 1'b0;
  reg         reset_n = 1'b0;
  reg         main_reset_n = 1'b0;
  wire [15:0] host_addr;
  wire [11:0] fw_addr;
  wire [7:0]  host_wdata, host_rdata, fw_wdata, fw_rdata;
  wire        host_wr, host_rd, host_rdata_oe, fw_wr, fw_rd, kbd_sys_irq, mouse_sys_irq;
  wire        fw_in_full_evt, fw_out_empty_evt, addr20_gate, alt_addr20_gate, alt_cpu_reset_n;
  integer     miscompares = 0;
  integer     compares = 0;
  integer     i;
  reg [7:0]   q;
  reg [7:0]   d;
  kbg_mailbox DUT (.clock(clock), .reset_n(reset_n), .main_reset_n(main_reset_n), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .fw_addr(fw_addr), .fw_wr(fw_wr), .fw_rd(fw_rd), .fw_wdata(fw_wdata),
    .fw_rdata(fw_rdata), .kbd_sys_irq(kbd_sys_irq), .mouse_sys_irq(mouse_sys_irq),
    .fw_in_full_evt(fw_in_full_evt), .fw_out_empty_evt(fw_out_empty_evt), .addr20_gate(addr20_gate),
    .alt_addr20_gate(alt_addr20_gate), .alt_cpu_reset_n(alt_cpu_reset_n));
  kbg_bus_model bm (.clock(clock), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .fw_addr(fw_addr), .fw_wr(fw_wr), .fw_rd(fw_rd),
    .fw_wdata(fw_wdata), .fw_rdata(fw_rdata));
  initial forever #2 clock = ~clock;
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wt;
    begin
      repeat (3) @(posedge clock);
      #1;
    end
  endtask
  function [7:0] stat(input o, input ib, input cd, input ax);
    begin
      stat = 8'h00;
      stat[`KBG_ST_OBF] = o;
      stat[`KBG_ST_IBF] = ib;
      stat[`KBG_ST_CD] = cd;
      stat[`KBG_ST_MOUSE_OUT_FULL_FLAG] = ax;
    end
  endfunction
  task end_sim;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #100000;
    miscompares = miscompares + 1;
    end_sim;
  end
  initial begin
    void'($urandom(38));
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    main_reset_n <= 1'b1;
    bm.xfer(0, 0, `KBG_FW_STATUS, 8'h00, q);
    chk("st0", 8'h00, q & 8'h2B);
    // pass 0 has the irq gate shut, passes 1 and 2 open it for keyboard then aux data
    for (i = 0; i < 3; i = i + 1) begin
      d = 8'($urandom);
      bm.xfer(0, 1, `KBG_FW_CONTROL, (i > 0) ? 8'h08 : 8'h00, q);
      bm.xfer(0, 1, (i == 2) ? `KBG_FW_AUX_DATA : `KBG_FW_KBD_DATA, d, q);
      wt;
      chk("irqs", {6'h0, i == 2, i == 1}, {6'h0, mouse_sys_irq, kbd_sys_irq});
      bm.xfer(0, 0, `KBG_FW_STATUS, 8'h00, q);
      chk("st", stat(1, 0, 0, i == 2), q & 8'h2B);
      bm.xfer(0, 0, `KBG_FW_KBD_FLAG, 8'h00, q);
      chk("flag", 8'(i < 2), q & 8'h01);
      bm.xfer(1, 0, `KBG_HOST_DATA, 8'h00, q);
      chk("hdat", d, q);
      chk("obe", 8'h03, {6'h0, host_rdata_oe, fw_out_empty_evt});
      wt;
      chk("clr", 8'h00, {6'h0, mouse_sys_irq, kbd_sys_irq});
    end
    bm.xfer(0, 1, `KBG_FW_CONTROL, 8'h0E, q);
    for (i = 3; i >= 0; i = i - 1) begin
      bm.xfer(0, 1, `KBG_FW_KBD_FLAG, 8'(i[0]), q);
      bm.xfer(0, 1, `KBG_FW_STATUS, {2'b00, i[1], 5'h00}, q);
      wt;
      chk("ovr", 8'(i), {6'h0, mouse_sys_irq, kbd_sys_irq});
      bm.xfer(0, 0, `KBG_FW_KBD_FLAG, 8'h00, q);
      chk("oflag", 8'(i[0]), q & 8'h01);
    end
    bm.xfer(0, 1, `KBG_FW_CONTROL, 8'h08, q);
    for (i = 0; i < 2; i = i + 1) begin
      d = 8'($urandom % 8'hD0); // stays clear of gate and pulse commands
      bm.xfer(1, 1, i ? `KBG_HOST_CMD : `KBG_HOST_DATA, d, q);
      chk("ibe", 8'h01, {7'h0, fw_in_full_evt});
      bm.xfer(0, 0, `KBG_FW_STATUS, 8'h00, q);
      chk("ibf", stat(0, 1, i, 0), q & 8'h2B);
      bm.xfer(0, 0, `KBG_FW_KBD_DATA, 8'h00, q);
      chk("in", d, q);
    end
    for (i = 0; i < 4; i = i + 1) begin
      d = (8'($urandom) & 8'hFD) | {6'h0, ~i[0], 1'b0};
      bm.xfer(1, 1, `KBG_HOST_CMD, `KBG_CMD_GATE, q);
      if (i[1])
        bm.xfer(1, 1, `KBG_HOST_CMD, `KBG_CMD_GATE, q);
      bm.xfer(1, 1, `KBG_HOST_DATA, d, q);
      bm.xfer(1, 1, `KBG_HOST_CMD, (i == 3) ? `KBG_CMD_PULSE_FE : `KBG_CMD_PULSE_FF, q);
      wt;
      chk("gate", {6'h0, d[`KBG_DATA_GATE_BIT], 1'b0}, {6'h0, addr20_gate, kbd_sys_irq});
      bm.xfer(0, 0, `KBG_FW_STATUS, 8'h00, q);
      chk("gst", 8'h00, q & 8'h23);
    end
    // a foreign command after the gate command aborts; the next data byte is plain data
    bm.xfer(1, 1, `KBG_HOST_CMD, `KBG_CMD_GATE, q);
    bm.xfer(1, 1, `KBG_HOST_CMD, 8'hAA, q);
    bm.xfer(1, 1, `KBG_HOST_DATA, 8'hFF, q);
    wt;
    bm.xfer(0, 0, `KBG_FW_STATUS, 8'h00, q);
    chk("abort", 8'h02, q & 8'h03);
    chk("agate", 8'h00, {7'h0, addr20_gate});
    bm.xfer(0, 0, `KBG_FW_KBD_DATA, 8'h00, q);
    chk("adat", 8'hFF, q);
    bm.xfer(0, 1, `KBG_FW_CONTROL, 8'h09, q);
    bm.xfer(0, 1, `KBG_FW_GATE_CTRL, 8'h01, q);
    wt;
    bm.xfer(0, 0, `KBG_FW_GATE_CTRL, 8'h00, q);
    chk("fwg", 8'h03, {6'h0, addr20_gate, q[0]});
    bm.xfer(0, 1, `KBG_FW_CONTROL, 8'h08, q);
    for (i = 0; i < 2; i = i + 1) begin
      bm.xfer(0, 1, i ? `KBG_FW_LATCH_RESET : `KBG_FW_LATCH_SET, 8'($urandom), q);
      wt;
      bm.xfer(0, 0, `KBG_FW_GATE_CTRL, 8'h00, q);
      chk("latch", i ? 8'h00 : 8'h03, {6'h0, addr20_gate, q[0]});
    end
    bm.xfer(1, 1, `KBG_HOST_ALT, 8'h03, q);
    bm.xfer(1, 0, `KBG_HOST_ALT, 8'h00, q);
    chk("p92off", 8'h01, {5'h0, host_rdata_oe, alt_addr20_gate, alt_cpu_reset_n});
    bm.xfer(0, 1, `KBG_FW_P92_ENABLE, 8'h01, q);
    bm.xfer(0, 1, `KBG_FW_P92_BAR, 8'hFF, q);
    bm.xfer(0, 0, `KBG_FW_P92_BAR, 8'h00, q);
    chk("bar", 8'h80, q);
    d = 8'($urandom) | 8'h02;
    bm.xfer(1, 1, `KBG_HOST_ALT, d, q);
    bm.xfer(1, 0, `KBG_HOST_ALT, 8'h00, q);
    chk("p92", d, q);
    chk("alt", {6'h0, ~d[0], 1'b1}, {6'h0, alt_cpu_reset_n, alt_addr20_gate});
    main_reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    main_reset_n <= 1'b1;
    bm.xfer(1, 0, `KBG_HOST_ALT, 8'h00, q);
    chk("p92rst", `KBG_ALT_RESET, q);
    end_sim;
  end
endmodule // tb_top
bind kbg_mailbox kbg_mailbox_props u_props (.clock(clock), .reset_n(reset_n), .main_reset_n(main_reset_n),
  .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
  .host_rdata_oe(host_rdata_oe), .fw_wr(fw_wr), .kbd_sys_irq(kbd_sys_irq), .mouse_sys_irq(mouse_sys_irq),
  .fw_in_full_evt(fw_in_full_evt), .fw_out_empty_evt(fw_out_empty_evt), .addr20_gate(addr20_gate),
  .alt_addr20_gate(alt_addr20_gate), .alt_cpu_reset_n(alt_cpu_reset_n));
